//--- hw/timer_b_cfg.svh
// offsets, field positions, reset values and timing counts of timer b
`ifndef TIMER_B_CFG_SVH
`define TIMER_B_CFG_SVH

// register indices; byte address is four times the index
`define TB_IDX_PIN_FUNC 6'h0a
`define TB_IDX_CLK_GATE 6'h0d
`define TB_IDX_CLK_MODE 6'h10
`define TB_IDX_OUT_EDGE 6'h11
`define TB_IDX_LOAD_LOW 6'h12
`define TB_IDX_LOAD_HIGH 6'h13

// field positions
`define TB_PIN_EVENT_BIT 0
`define TB_PIN_WAVE_BIT 3
`define TB_GATE_STOP_BIT 0

// reset values
`define TB_RST_NIBBLE 4'h0
`define TB_RST_MODE 3'h0
`define TB_RST_COUNT 8'h00

// count limits
`define TB_COUNT_TOP 8'hff
`define TB_FREE_START 8'h00

// prescaled input periods in instruction cycles, clock select codes 0..6
`define TB_PER_SEL0 12'h800
`define TB_PER_SEL1 12'h200
`define TB_PER_SEL2 12'h080
`define TB_PER_SEL3 12'h020
`define TB_PER_SEL4 12'h008
`define TB_PER_SEL5 12'h004
`define TB_PER_SEL6 12'h002
`define TB_SEL_EVENT 3'h7

// instructions to wait before a clock/reload mode write takes effect
`define TB_MODE_DELAY_INSTR 2

`endif

//--- hw/timer_b_pkg.sv
// types shared by the timer b design files
package timer_b_pkg;

    typedef enum logic [1:0] {
        EDGE_FALL,
        EDGE_RISE,
        EDGE_BOTH,
        EDGE_FALL_ALT
    } edge_sel_t;

    typedef struct packed {
        logic reload;
        logic [2:0] clkSel;
    } clk_mode_t;

    typedef struct packed {
        logic pwm;
        edge_sel_t edgeSel;
    } out_edge_t;

endpackage

//--- hw/timer_b_prescaler.sv
// input clock selection: prescaler taps or external event edges
`timescale 1ns/10ps
`include "timer_b_cfg.svh"

module timer_b_prescaler (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic run,
    input wire logic [2:0] clkSel,
    input wire timer_b_pkg::edge_sel_t edgeSel,
    input wire logic eventEnable,
    input wire logic eventIn,
    output logic tick
);
    logic [10:0] div_q;
    logic eventPrev_q;
    logic [11:0] period;
    logic [10:0] mask;
    wire rise = eventIn & ~eventPrev_q;
    wire fall = ~eventIn & eventPrev_q;
    logic edgeHit;

    always_comb begin
        case (clkSel)
            3'h0: period = `TB_PER_SEL0;
            3'h1: period = `TB_PER_SEL1;
            3'h2: period = `TB_PER_SEL2;
            3'h3: period = `TB_PER_SEL3;
            3'h4: period = `TB_PER_SEL4;
            3'h5: period = `TB_PER_SEL5;
            3'h6: period = `TB_PER_SEL6;
            default: period = `TB_PER_SEL6;
        endcase
    end

    assign mask = 11'(period - 12'h001);

    always_comb begin
        case (edgeSel)
            timer_b_pkg::EDGE_RISE: edgeHit = rise;
            timer_b_pkg::EDGE_BOTH: edgeHit = rise | fall;
            default: edgeHit = fall;
        endcase
    end

    assign tick = run & ((clkSel == `TB_SEL_EVENT) ? (eventEnable & edgeHit)
                                                   : ((div_q & mask) == mask));

    // prescaler stops with the module clock in standby
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= 11'h000;
            eventPrev_q <= 1'b0;
        end else if (run) begin
            div_q <= div_q + 11'h001;
            eventPrev_q <= eventIn;
        end
    end
endmodule

//--- hw/timer_b_wave_out.sv
// timer output waveform: toggle or pwm
`timescale 1ns/10ps
`include "timer_b_cfg.svh"

module timer_b_wave_out (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic overflow,
    input wire logic [7:0] count,
    input wire logic [7:0] loadValue,
    input wire logic pwm,
    input wire logic reload,
    output logic waveOut
);
    logic waveOut_q;
    logic [7:0] duty_q;
    logic waveOut_d;

    always_comb begin
        waveOut_d = waveOut_q;
        if (!pwm) begin
            if (overflow) waveOut_d = ~waveOut_q;
        end else if (reload) begin
            waveOut_d = (count == `TB_COUNT_TOP);
        end else begin
            waveOut_d = (count >= duty_q);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            waveOut_q <= 1'b0;
            duty_q <= `TB_RST_COUNT;
        end else begin
            waveOut_q <= waveOut_d;
            if (overflow) duty_q <= loadValue;
        end
    end

    assign waveOut = waveOut_q;
endmodule

//--- hw/timer_b_register_interface.sv
// 8-bit up-counting timer b with its apb register file
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`include "timer_b_cfg.svh"

// How it works
// - clock select picks prescaled 2048..2 cycle periods, all-ones picks event pin
// - 3-bit write-only mode register sets output mode and event edge; resets to zero
// - reset clears lower load nibble; upper load nibble is cleared too, for determinism
// - upper load nibble write loads the counter with it and the stored lower nibble at once, except in standby or in pwm without reload
// - lower load nibble persists, so a lone upper write reloads the counter
// - reading upper count nibble returns it and latches the lower nibble
// - lower count read returns the latched nibble, giving a consistent byte
// - write-only pin function register routes shared pins; resets to zero
// - write-only module standby register gates the timer clock; resets to running
// - toggle mode inverts the output on the clock after the count wraps from ff
// - clock and reload mode writes take effect two instructions later
// - standby bit zero halts the timer; mode registers keep their values
// - pwm without reload takes new duty next frame; with reload restarts at once
module timer_b_register_interface (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic eventPinIn,
    output logic eventFuncSel,
    output logic waveOut,
    output logic waveOutEn,
    output logic overflowPulse
);
    localparam int ModeDelay = `TB_MODE_DELAY_INSTR;

    // software visible registers
    logic [3:0] pinFunc_q;
    logic [3:0] clkGate_q;
    timer_b_pkg::out_edge_t outEdge_q;
    logic [3:0] loadLow_q;
    logic [3:0] loadHigh_q;
    timer_b_pkg::clk_mode_t modeAct_q;
    timer_b_pkg::clk_mode_t modeStage_q [ModeDelay];

    // count and read path
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic [3:0] readLowHold_q;
    logic [3:0] pendLow_q;
    logic pendCapture_q;
    logic [31:0] prdata_q;
    logic overflow_q;

    // apb decode
    wire [5:0] regIdx = paddr[7:2];
    wire setupPhase = psel & ~penable;
    wire accessPhase = psel & penable;
    wire wrEn = accessPhase & pwrite;
    wire hitPinFunc = (regIdx == `TB_IDX_PIN_FUNC);
    wire hitClkGate = (regIdx == `TB_IDX_CLK_GATE);
    wire hitClkMode = (regIdx == `TB_IDX_CLK_MODE);
    wire hitOutEdge = (regIdx == `TB_IDX_OUT_EDGE);
    wire hitLoadLow = (regIdx == `TB_IDX_LOAD_LOW);
    wire hitLoadHigh = (regIdx == `TB_IDX_LOAD_HIGH);
    wire mapped = hitPinFunc | hitClkGate | hitClkMode | hitOutEdge | hitLoadLow
                  | hitLoadHigh;
    wire aligned = (paddr[1:0] == 2'b00);
    wire okAccess = mapped & aligned;
    wire wrLoadLow = wrEn & okAccess & hitLoadLow;
    wire wrLoadHigh = wrEn & okAccess & hitLoadHigh;
    wire rdSetupHigh = setupPhase & ~pwrite & aligned & hitLoadHigh;

    wire run = ~clkGate_q[`TB_GATE_STOP_BIT];
    wire tick;
    wire [7:0] loadValue = {loadHigh_q, loadLow_q};
    wire [7:0] newLoad = {pwdata[3:0], loadLow_q};
    wire pwmFreeRun = outEdge_q.pwm & ~modeAct_q.reload;
    // free-running pwm keeps the frame, duty waits for overflow
    wire loadNow = wrLoadHigh & ~pwmFreeRun;
    wire atTop = (count_q == `TB_COUNT_TOP);
    wire wrap = run & tick & atTop & ~loadNow;

    // zero wait states; the answer is always ready in the access phase
    assign pready = 1'b1;
    assign pslverr = accessPhase & ~okAccess;
    assign prdata = prdata_q;

    assign eventFuncSel = pinFunc_q[`TB_PIN_EVENT_BIT];
    assign waveOutEn = pinFunc_q[`TB_PIN_WAVE_BIT];
    assign overflowPulse = overflow_q;

    timer_b_prescaler i_timer_b_prescaler (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .run(run),
        .clkSel(modeAct_q.clkSel),
        .edgeSel(outEdge_q.edgeSel),
        .eventEnable(eventFuncSel),
        .eventIn(eventPinIn),
        .tick(tick)
    );

    timer_b_wave_out i_timer_b_wave_out (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .overflow(overflow_q),
        .count(count_q),
        .loadValue(loadValue),
        .pwm(outEdge_q.pwm),
        .reload(modeAct_q.reload),
        .waveOut(waveOut)
    );

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pinFunc_q <= `TB_RST_NIBBLE;
            clkGate_q <= `TB_RST_NIBBLE;
            outEdge_q <= `TB_RST_MODE;
        end else if (wrEn & okAccess) begin
            if (hitPinFunc) pinFunc_q <= pwdata[3:0];
            if (hitClkGate) clkGate_q <= pwdata[3:0];
            if (hitOutEdge) outEdge_q <= pwdata[2:0];
        end
    end

    // lower nibble resets, upper nibble cleared only for determinism
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            loadLow_q <= `TB_RST_NIBBLE;
            loadHigh_q <= `TB_RST_NIBBLE;
        end else begin
            // lower write only stores the nibble
            if (wrLoadLow) loadLow_q <= pwdata[3:0];
            if (wrLoadHigh) loadHigh_q <= pwdata[3:0];
        end
    end

    // mode write passes a delay line, one stage per instruction
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < ModeDelay; i++) begin
                modeStage_q[i] <= 4'h0;
            end
            modeAct_q <= 4'h0;
        end else begin
            modeStage_q[0] <= modeStage_q[0];
            if (wrEn & okAccess & hitClkMode) modeStage_q[0] <= pwdata[3:0];
            for (int i = 1; i < ModeDelay; i++) begin
                modeStage_q[i] <= modeStage_q[i-1];
            end
            modeAct_q <= modeStage_q[ModeDelay-1];
        end
    end

    always_comb begin
        count_d = count_q;
        if (!run) begin
            count_d = count_q;
        end else if (loadNow) begin
            // upper write loads the full byte
            count_d = newLoad;
        end else if (tick) begin
            // count up, wrap to load value or zero
            if (atTop) begin
                count_d = modeAct_q.reload ? loadValue : `TB_FREE_START;
            end else begin
                count_d = count_q + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= `TB_RST_COUNT;
            overflow_q <= 1'b0;
        end else begin
            count_q <= count_d;
            overflow_q <= wrap;
        end
    end

    // read data is sampled in the setup phase so prdata comes from a flop;
    // the low nibble is snapped in the same cycle as the high nibble
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prdata_q <= 32'h0000_0000;
            pendLow_q <= `TB_RST_NIBBLE;
            pendCapture_q <= 1'b0;
        end else if (setupPhase) begin
            prdata_q <= 32'h0000_0000;
            pendCapture_q <= rdSetupHigh;
            // upper read returns live upper nibble
            if (rdSetupHigh) begin
                prdata_q <= {28'h000_0000, count_q[7:4]};
                pendLow_q <= count_q[3:0];
            end
            // lower read returns the latched nibble
            if (~pwrite & aligned & hitLoadLow) begin
                prdata_q <= {28'h000_0000, readLowHold_q};
            end
        end
    end

    // latch commits at the access edge that ends the upper read
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            readLowHold_q <= `TB_RST_NIBBLE;
        end else if (accessPhase & pendCapture_q) begin
            readLowHold_q <= pendLow_q;
        end
    end
endmodule

//--- bench/timer_b_asserts.sv
// port-level assertions for the timer b register interface
`timescale 1ns/10ps
module timer_b_asserts (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic eventPinIn,
    input wire logic eventFuncSel,
    input wire logic waveOut,
    input wire logic waveOutEn,
    input wire logic overflowPulse
);
    logic pwm_q;
    wire rdWo = paddr inside {8'h28, 8'h34, 8'h40, 8'h44};
    wire mapped = rdWo || paddr inside {8'h48, 8'h4c};
    wire rdAcc = psel && penable && !pwrite;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // output mode shadow, needed to know when toggling is due
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            pwm_q <= 1'b0;
        else if (psel && penable && pwrite && paddr == 8'h44)
            pwm_q <= pwdata[2];
    end
    sequence sPinWrite;
        psel && penable && pwrite && paddr == 8'h28;
    endsequence
    a_ready_const: assert property (pready)
        else $error("pready low");
    a_err_unmapped: assert property (pslverr == (psel && penable && !mapped))
        else $error("pslverr wrong");
    a_pin_event: assert property (sPinWrite |=> eventFuncSel == $past(pwdata[0]))
        else $error("event pin select wrong");
    a_pin_wave: assert property (sPinWrite |=> waveOutEn == $past(pwdata[3]))
        else $error("wave pin enable wrong");
    a_pin_hold: assert property (!(psel && penable && pwrite && paddr == 8'h28)
        |=> $stable({eventFuncSel, waveOutEn}))
        else $error("pin select changed");
    a_wo_zero: assert property (rdAcc && rdWo |-> prdata == 32'h0)
        else $error("write-only read not zero");
    a_upper_zero: assert property (rdAcc |-> prdata[31:4] == 28'h0)
        else $error("read upper bits set");
    a_pulse_single: assert property (overflowPulse |=> !overflowPulse)
        else $error("overflow pulse too long");
    a_toggle_wave: assert property (overflowPulse && !pwm_q |=> $changed(waveOut))
        else $error("toggle missing");
endmodule

//--- bench/test_timer_b_register_interface.sv
// self-checking bench for the timer b register interface
`timescale 1ns/10ps
module test_timer_b_register_interface;
    logic clk_sys = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, eventPinIn = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rng = 32'd66, r;
    logic pready, pslverr, eventFuncSel, waveOut, waveOutEn, overflowPulse;
    logic [32:0] expQ[$];
    logic [7:0] woA[4] = '{8'h28, 8'h34, 8'h40, 8'h44};
    int errCount = 0, nCompared = 0, nPulse = 0;
    timer_b_register_interface i_timer_b_register_interface (.clk_sys(clk_sys),
        .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .eventPinIn(eventPinIn), .eventFuncSel(eventFuncSel), .waveOut(waveOut),
        .waveOutEn(waveOutEn), .overflowPulse(overflowPulse));
    always #5 clk_sys = ~clk_sys;
    function automatic logic [31:0] xorshift();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    task cmp(input logic [32:0] got, input logic [32:0] exp);
        nCompared++;
        if (got !== exp) begin
            errCount++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr)
            expQ.push_back(e);
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task end_sim();
        $display("compared %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // read results taken mid-cycle, away from the launching edge
    always @(negedge clk_sys) begin
        if (psel && penable && !pwrite && expQ.size() > 0)
            cmp({pslverr, prdata}, expQ.pop_front());
        if (overflowPulse === 1'b1)
            nPulse++;
    end
    task span(input int n, input int lo, input int hi);
        nPulse = 0;
        repeat (n) @(posedge clk_sys);
        cmp({32'h0, nPulse >= lo && nPulse <= hi}, 33'h1);
    endtask
    initial begin
        #100us;
        errCount++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        cmp({eventFuncSel, waveOutEn, waveOut}, 33'h0);
        apb(1, 8'h28, 32'h9, 0);
        @(negedge clk_sys);
        cmp({eventFuncSel, waveOutEn}, 33'h3);
        $display("pins done");
        // early, before the slow reset prescaler first ticks
        for (int i = 0; i < 4; i++) begin
            r = xorshift();
            apb(1, 8'h48, r[3:0], 0);
            apb(1, 8'h4c, r[7:4], 0);
            apb(0, 8'h4c, 0, {29'h0, r[7:4]});
            apb(0, 8'h48, 0, {29'h0, r[3:0]});
        end
        apb(1, 8'h48, ~r[3:0], 0);
        apb(0, 8'h4c, 0, {29'h0, r[7:4]});
        apb(0, 8'h48, 0, {29'h0, r[3:0]});
        apb(1, 8'h4c, ~r[7:4], 0);
        apb(0, 8'h4c, 0, {29'h0, ~r[7:4]});
        apb(0, 8'h48, 0, {29'h0, ~r[3:0]});
        $display("load and read done");
        apb(0, 8'h3c, 0, {1'b1, 32'h0});
        apb(0, 8'h49, 0, {1'b1, 32'h0});
        for (int i = 0; i < 4; i++)
            apb(0, woA[i], 0, 0);
        $display("refusals done");
        apb(1, 8'h44, 32'h0, 0);
        apb(1, 8'h48, 32'he, 0);
        apb(1, 8'h40, 32'he, 0);
        repeat (4) @(posedge clk_sys);
        apb(1, 8'h4c, 32'hf, 0);
        span(200, 49, 51);
        apb(1, 8'h40, 32'h6, 0);
        span(1024, 2, 3);
        apb(1, 8'h34, 32'h1, 0);
        span(1100, 0, 0);
        apb(1, 8'h34, 32'h0, 0);
        span(1100, 1, 5);
        $display("timing done");
        apb(1, 8'h44, 32'h1, 0);
        apb(1, 8'h40, 32'hf, 0);
        repeat (4) @(posedge clk_sys);
        apb(1, 8'h4c, 32'hf, 0);
        nPulse = 0;
        repeat (16) begin
            repeat (3) @(posedge clk_sys);
            eventPinIn <= ~eventPinIn;
        end
        repeat (10) @(posedge clk_sys);
        cmp({1'b0, nPulse}, 33'h4);
        $display("events done");
        end_sim();
    end
endmodule
bind timer_b_register_interface timer_b_asserts i_timer_b_asserts (.clk_sys(clk_sys),
    .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eventPinIn(eventPinIn), .eventFuncSel(eventFuncSel), .waveOut(waveOut),
    .waveOutEn(waveOutEn), .overflowPulse(overflowPulse));
